/* File: alss_pkg.sv */
/*
  alss_pkg: constants for the serializer and sync block.
  Assumes one sample clock domain; used as alss_pkg::name, never imported.
*/
// Notes on behaviour
// [R1] accepted sync pulse resets decimation and interleave dividers together
// [R2] decimate-by-2 emits one code per two samples; phase arbitrary without sync
// [R3] filter sync from the sync input is active after reset, no write needed
// [R4] controller keeps the pattern align select cleared for filter alignment
// [R5] sync pulse is held high at least one sample clock cycle
// [R6] with pattern align select set, sync restarts all ramp generators together
// [R7] pattern align select set disables divider sync by the pulse
// [R8] in interleave mode sync resets the odd/even sampling divider
// [R9] non-interleaved: all channels sample on the same edge, sync leaves it alone
// [R10] bit clock runs 6x, 5x or 7x for 12x, 10x, 14x; 12x at reset
// [R11] 14x serialization is available for averaged or decimated wide words
// [R12] 12x: each lane carries its 12-bit word, shared 6x bit clock, 1x frame
// [R13] 12x: lane bit rate is twelve times the sample rate
// [R14] 10x: only the ten upper bits of each sample are sent
// [R15] 10x: lane bit rate is ten times the sample rate
// [R16] msb-first and lsb-first bit order both supported per frame
// [R17] 2-bit bit clock phase field, reset value binary 10
// [R18] separate rise and fall data delay fields, codes 0, 33, 72, 120 ps
// [R19] delay and phase encodings behave the same in 10x and 12x
// [R20] frame clock edge marks the first serial bit of each word; code gives no edge when a sync lands in the first half of a word
package alss_pkg;
  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIMING = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  // control fields
  localparam int CTRL_SER_LSB = 0;
  localparam int CTRL_MSB_FIRST = 2;
  localparam int CTRL_PAT_ALIGN = 3;
  localparam int CTRL_DECIM = 4;
  localparam int CTRL_INTERLEAVE = 5;
  localparam int CTRL_RAMP = 6;
  // timing fields
  localparam int TIM_PHASE_LSB = 0;
  localparam int TIM_DRISE_LSB = 2;
  localparam int TIM_DFALL_LSB = 4;
  localparam int TIM_CLKDLY_LSB = 6;
  // serialization factor codes
  localparam logic [1:0] SER_12X = 2'h0;
  localparam logic [1:0] SER_10X = 2'h1;
  localparam logic [1:0] SER_14X = 2'h2;
  // bits per word, and bit clock multiples (half of them, ddr)
  localparam logic [3:0] BITS_12X = 4'hc;
  localparam logic [3:0] BITS_10X = 4'ha;
  localparam logic [3:0] BITS_14X = 4'he;
  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h0004;
  localparam logic [15:0] TIMING_RESET = 16'h0002;
  localparam logic [1:0] PHASE_RESET = 2'h2;
  // typical data delays in ps per code
  localparam int DELAY_PS_0 = 0;
  localparam int DELAY_PS_1 = 33;
  localparam int DELAY_PS_2 = 72;
  localparam int DELAY_PS_3 = 120;
  typedef enum logic [2:0] {
    ALSS_IDLE = 3'b001,
    ALSS_ARMED = 3'b010,
    ALSS_HELD = 3'b100
  } alss_sync_type;
endpackage

/* File: alss_serializer.sv */
/*
  alss_serializer: sync handling and per-lane serializer for an 8-lane adc output.
  Assumes clk is the bit-slot clock: one serial bit (one half of the ddr bit clock)
  per cycle; the sample rate is clk divided by the word length. Samples and the
  sync pin are synchronous to clk. Registers on a plain strobe port.
*/
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
module alss_serializer #(
  parameter int LANES = 8,
  parameter int SAMPLE_W = 14
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // sample input, one word per lane, taken at each frame start (every other one with decimation)
  input wire logic [LANES*SAMPLE_W-1:0] sample_in,
  output logic sample_take,
  // sync pin
  input wire logic sync_in,
  // lvds side
  output logic [LANES-1:0] lane_out,
  output logic bit_clock_out,
  output logic frame_clock_out,
  // per-edge delay codes for the analog output stage
  output logic [1:0] data_rise_delay,
  output logic [1:0] data_fall_delay,
  output logic [1:0] bitclk_edge_delay,
  // interleave sampling select and ramp restart to the converter core
  output logic odd_sample_sel,
  output logic ramp_restart
);
  logic rst_meta_reg, rst_sync_reg;
  logic [15:0] ctrl_reg, timing_reg;
  logic [15:0] rdata_reg;
  logic sync_prev_reg;
  alss_pkg::alss_sync_type sync_state_reg, sync_state_next;
  logic [3:0] slot_reg, slot_next;
  logic decim_reg, inter_reg;
  logic [LANES*SAMPLE_W-1:0] word_reg;
  logic [LANES-1:0] lane_reg;
  logic frame_reg, bclk_reg;
  logic [11:0] ramp_reg;
  logic [7:0] sync_count_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire logic srst_n = rst_sync_reg;

  // decoded controls
  wire logic [1:0] ser_mode = ctrl_reg[alss_pkg::CTRL_SER_LSB +: 2];
  wire logic msb_first = ctrl_reg[alss_pkg::CTRL_MSB_FIRST];
  wire logic pattern_align_select = ctrl_reg[alss_pkg::CTRL_PAT_ALIGN];
  wire logic decim_en = ctrl_reg[alss_pkg::CTRL_DECIM];
  wire logic interleave_en = ctrl_reg[alss_pkg::CTRL_INTERLEAVE];
  wire logic ramp_en = ctrl_reg[alss_pkg::CTRL_RAMP];
  wire logic [1:0] phase_sel = timing_reg[alss_pkg::TIM_PHASE_LSB +: 2];

  // word length per mode; unknown codes fall back to the default 12x
  function automatic logic [3:0] word_bits(input logic [1:0] mode);
    case (mode)
      alss_pkg::SER_10X: word_bits = alss_pkg::BITS_10X; // R14 R15
      alss_pkg::SER_14X: word_bits = alss_pkg::BITS_14X; // R11
      default: word_bits = alss_pkg::BITS_12X; // R12 R13
    endcase
  endfunction

  wire logic [3:0] nbits = word_bits(ser_mode);
  wire logic last_slot = (slot_reg == nbits - 4'h1);
  wire logic sync_rise = sync_in & ~sync_prev_reg;
  // a rising edge counts once; pulse of one cycle is enough
  wire logic sync_accept = (sync_state_reg == alss_pkg::ALSS_IDLE) & sync_rise; // R5
  wire logic div_sync = sync_accept & ~pattern_align_select; // R1 R3 R4 R7
  wire logic pat_sync = sync_accept & pattern_align_select; // R6

  // register port
  wire logic hit_ctrl = reg_addr == alss_pkg::ADDR_CTRL;
  wire logic hit_timing = reg_addr == alss_pkg::ADDR_TIMING;
  wire logic hit_status = reg_addr == alss_pkg::ADDR_STATUS;
  wire logic [15:0] status_word = {sync_count_reg, 3'h0, decim_reg, inter_reg, sync_in, ser_mode};
  wire logic [15:0] rd_mux = hit_ctrl ? ctrl_reg : hit_timing ? timing_reg : hit_status ? status_word : 16'h0000;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= alss_pkg::CTRL_RESET;
      timing_reg <= alss_pkg::TIMING_RESET; // R17
    end else if (!srst_n) begin
      ctrl_reg <= alss_pkg::CTRL_RESET;
      timing_reg <= alss_pkg::TIMING_RESET;
    end else if (reg_write) begin
      if (hit_ctrl)
        ctrl_reg <= reg_wdata;
      if (hit_timing)
        timing_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      rdata_reg <= 16'h0000;
    else
      rdata_reg <= reg_read ? rd_mux : 16'h0000;
  end
  assign reg_rdata = rdata_reg;

  // sync edge tracker: wait for the pin to fall before rearming
  always_comb begin
    sync_state_next = sync_state_reg;
    case (sync_state_reg)
      alss_pkg::ALSS_IDLE: if (sync_rise) sync_state_next = alss_pkg::ALSS_HELD;
      alss_pkg::ALSS_HELD: if (!sync_in) sync_state_next = alss_pkg::ALSS_ARMED;
      alss_pkg::ALSS_ARMED: sync_state_next = alss_pkg::ALSS_IDLE;
      default: sync_state_next = alss_pkg::ALSS_IDLE;
    endcase
  end

  // sync with pattern align select clear restarts the frame too, so all lanes start a fresh word together
  // limitation: a sync landing in the first half of a word leaves frame high, so no frame edge
  always_comb begin
    if (div_sync || last_slot || slot_reg >= nbits)
      slot_next = 4'h0; // R1
    else
      slot_next = slot_reg + 4'h1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_state_reg <= alss_pkg::ALSS_IDLE;
      sync_prev_reg <= 1'b0;
      slot_reg <= 4'h0;
      decim_reg <= 1'b0;
      inter_reg <= 1'b0;
      sync_count_reg <= 8'h00;
    end else begin
      sync_state_reg <= srst_n ? sync_state_next : alss_pkg::ALSS_IDLE;
      sync_prev_reg <= sync_in;
      slot_reg <= srst_n ? slot_next : 4'h0;
      if (sync_accept)
        sync_count_reg <= sync_count_reg + 8'h01;
      // dividers toggle once per sample; sync forces a known phase
      if (div_sync) begin
        decim_reg <= 1'b0; // R1 R2
        inter_reg <= 1'b0; // R8
      end else if (last_slot) begin
        decim_reg <= decim_en ? ~decim_reg : 1'b0; // R2
        inter_reg <= interleave_en ? ~inter_reg : 1'b0; // R9
      end
    end
  end

  // frame start: load on slot 0; with decimation only every other sample
  wire logic frame_start = (slot_next == 4'h0);
  wire logic load = frame_start & (~decim_en | ~decim_reg); // R2
  assign sample_take = load;
  assign odd_sample_sel = inter_reg & interleave_en; // R8 R9

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      ramp_reg <= 12'h000;
    else if (pat_sync)
      ramp_reg <= 12'h000; // R6
    else if (load)
      ramp_reg <= ramp_reg + 12'h001;
  end
  assign ramp_restart = pat_sync;

  // next bit index per mode; msb-first counts down, lsb-first up; 10x drops low two
  function automatic logic [3:0] bit_index(input logic [3:0] slot, input logic [3:0] bits,
      input logic msb);
    logic [3:0] base;
    base = (bits == alss_pkg::BITS_10X) ? 4'h2 : 4'h0; // R14
    bit_index = msb ? (base + bits - 4'h1 - slot) : (base + slot); // R16
  endfunction

  wire logic [3:0] next_idx = bit_index(slot_next, nbits, msb_first);
  // 12-bit samples sit in the low bits; 14x words use the full width
  logic [LANES-1:0] lane_next;
  logic [LANES*SAMPLE_W-1:0] word_next;
  always_comb begin
    word_next = load ? sample_in : word_reg;
    for (int i = 0; i < LANES; i++) begin
      if (ramp_en && load)
        word_next[i*SAMPLE_W +: SAMPLE_W] = SAMPLE_W'(ramp_reg);
      lane_next[i] = word_next[i*SAMPLE_W + int'(next_idx)]; // R12 R16
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      word_reg <= '0;
      lane_reg <= '0;
      frame_reg <= 1'b0;
      bclk_reg <= 1'b0;
    end else begin
      word_reg <= word_next;
      lane_reg <= lane_next;
      // frame high for the first half of the word, rising on bit 0
      frame_reg <= (slot_next < (nbits >> 1)); // R20
      // one ddr bit clock edge per bit slot: nbits/2 periods per sample
      bclk_reg <= frame_start ? 1'b1 : ~bclk_reg; // R10
    end
  end

  assign lane_out = lane_reg;
  assign frame_clock_out = frame_reg;
  // phase 10 puts the bit clock edge centred, as the default; others invert or track
  assign bit_clock_out = phase_sel[1] ? bclk_reg ^ phase_sel[0] : ~(bclk_reg ^ phase_sel[0]); // R17 R19
  assign data_rise_delay = timing_reg[alss_pkg::TIM_DRISE_LSB +: 2]; // R18 R19
  assign data_fall_delay = timing_reg[alss_pkg::TIM_DFALL_LSB +: 2]; // R18
  assign bitclk_edge_delay = timing_reg[alss_pkg::TIM_CLKDLY_LSB +: 2];
endmodule

/* File: alss_serializer_asserts.sv */
/* port checker for alss_serializer: readback, delay fields, framing, sync.
   assumes registers change only through the strobe port. */
`timescale 1ns/10ps
module alss_serializer_asserts #(
  parameter int LANES = 8,
  parameter int SAMPLE_W = 14
) (
  // clock, reset, registers
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  // stream and sync
  input wire logic [LANES*SAMPLE_W-1:0] sample_in,
  input wire logic sample_take,
  input wire logic sync_in,
  input wire logic [LANES-1:0] lane_out,
  input wire logic bit_clock_out,
  input wire logic frame_clock_out,
  input wire logic [1:0] data_rise_delay,
  input wire logic [1:0] data_fall_delay,
  input wire logic [1:0] bitclk_edge_delay,
  input wire logic ramp_restart
);
  logic [15:0] ctrl_reg;
  logic [15:0] tim_reg;
  wire logic [1:0] mode = ctrl_reg[1:0];
  wire logic first_msb = (mode == alss_pkg::SER_14X) ? sample_in[13] : sample_in[11];
  wire logic first_lsb = (mode == alss_pkg::SER_10X) ? sample_in[2] : sample_in[0];
  wire logic first_bit = ctrl_reg[2] ? first_msb : first_lsb;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= alss_pkg::CTRL_RESET;
      tim_reg <= alss_pkg::TIMING_RESET;
    end else if (reg_write && reg_addr == alss_pkg::ADDR_CTRL) begin
      ctrl_reg <= reg_wdata;
    end else if (reg_write && reg_addr == alss_pkg::ADDR_TIMING) begin
      tim_reg <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence rd_at(a);
    $past(reg_read) && $past(reg_addr) == a;
  endsequence
  // low for two clock cycles, so the tracker is surely idle
  sequence sync_rise;
    sync_in && !$past(sync_in) && !$past(sync_in, 2);
  endsequence
  a_ctrl_readback: assert property (rd_at(alss_pkg::ADDR_CTRL) |-> reg_rdata == ctrl_reg)
    else $error("ctrl readback differs");
  a_timing_readback: assert property (rd_at(alss_pkg::ADDR_TIMING) |-> reg_rdata == tim_reg)
    else $error("timing readback differs");
  a_delay_fields: assert property ({bitclk_edge_delay, data_fall_delay, data_rise_delay} == tim_reg[7:2])
    else $error("delay codes differ from register");
  a_frame_marks_word: assert property (sample_take |=> $rose(frame_clock_out))
    else $error("frame clock not rising at word start");
  a_first_bit: assert property (sample_take && !ctrl_reg[6] |=> lane_out[0] == $past(first_bit))
    else $error("first serial bit wrong");
  a_bitclk_phase: assert property ($rose(frame_clock_out) |-> bit_clock_out == (tim_reg[1] ^ tim_reg[0]))
    else $error("bit clock phase wrong at word start");
  a_sync_ramp: assert property (sync_rise and ctrl_reg[3] |-> ramp_restart)
    else $error("ramp not restarted by sync");
  a_sync_align: assert property (sync_rise and !ctrl_reg[3] |-> !ramp_restart ##1 frame_clock_out)
    else $error("sync did not restart the word");
  c_sync_align: cover property (sync_rise and !ctrl_reg[3]);
  c_sync_ramp: cover property (ramp_restart);
  c_decim_take: cover property (sample_take && ctrl_reg[4]);
endmodule
bind alss_serializer alss_serializer_asserts #(.LANES(LANES), .SAMPLE_W(SAMPLE_W)) u_alss_serializer_asserts (.*);

/* File: alss_rx_model.sv */
/* capture receiver model: deserializes every lane from the frame clock.
   assumes frame rises with the first bit; width and order set by the bench. */
`timescale 1ns/10ps
module alss_rx_model #(
  parameter int LANES = 8
) (
  // stream in
  input wire logic clk,
  input wire logic [LANES-1:0] lane_in,
  input wire logic frame_in,
  // word format
  input wire logic [3:0] nbits,
  input wire logic msb_first,
  // words out
  output logic [LANES*14-1:0] word,
  output logic word_valid
);
  logic frame_d = 1'b0;
  logic [3:0] idx = 4'hf;
  logic [LANES*14-1:0] acc;
  always @(posedge clk) begin
    idx = (frame_in && !frame_d) ? 4'h0 : ((idx == 4'hf) ? idx : idx + 4'h1);
    frame_d = frame_in;
    if (idx == 4'h0) acc = '0;
    for (int l = 0; l < LANES; l++)
      if (idx < nbits) acc[l*14 + (msb_first ? nbits - 4'h1 - idx : idx)] = lane_in[l];
    word_valid <= (idx == nbits - 4'h1);
    if (idx == nbits - 4'h1) word <= acc;
  end
endmodule

/* File: alss_tb.sv */
/* self-checking bench for alss_serializer with the capture receiver model.
   assumes package, design, checker and model are compiled first. */
`timescale 1ns/10ps
module tb;
  localparam int LANES = 8;
  localparam int SW = 14;
  typedef struct {logic [1:0] mode; logic msb; logic [13:0] d;} alss_row_type;
  alss_row_type rows [6] = '{'{2'h0, 1'b1, 14'h0a5c}, '{2'h3, 1'b0, 14'h03c1}, '{2'h1, 1'b1, 14'h07f3},
    '{2'h1, 1'b0, 14'h0d2e}, '{2'h2, 1'b1, 14'h2a5b}, '{2'h2, 1'b0, 14'h1234}};
  logic clk = 1'b0, rstn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, sync_in = 1'b0, rx_msb = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, st0, st1;
  logic [LANES*SW-1:0] sample_in = '0, rx_word;
  logic [LANES-1:0] lane_out;
  logic [1:0] data_rise_delay, data_fall_delay, bitclk_edge_delay;
  logic [3:0] rx_bits = 4'hc;
  logic sample_take, bit_clock_out, frame_clock_out, odd_sample_sel, ramp_restart, rx_valid, rr, fr, bc_prev;
  int n_fail = 0, samples_checked = 0, cycles = 0, takes;
  alss_serializer #(.LANES(LANES), .SAMPLE_W(SW)) u_alss_serializer (.*);
  alss_rx_model #(.LANES(LANES)) u_alss_rx_model (.clk(clk), .lane_in(lane_out), .frame_in(frame_clock_out),
    .nbits(rx_bits), .msb_first(rx_msb), .word(rx_word), .word_valid(rx_valid));
  initial forever #50 clk = ~clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  // rise only while frame is low, so the restarted word shows a frame edge
  task automatic pulse_sync();
    @(posedge clk);
    while (frame_clock_out !== 1'b1) @(posedge clk);
    while (frame_clock_out !== 1'b0) @(posedge clk);
    sync_in <= 1'b1;
    @(posedge clk);
    rr = ramp_restart;
    sync_in <= 1'b0;
    @(posedge clk);
    fr = frame_clock_out;
    repeat (3) @(posedge clk);
  endtask
  task automatic next_word();
    @(posedge clk);
    repeat (40) if (rx_valid !== 1'b1) @(posedge clk);
  endtask
  function automatic logic [15:0] expect_word(int r, int l);
    logic [13:0] d;
    d = rows[r].d ^ 14'(l);
    if (rows[r].mode == 2'h1) return {6'h00, d[11:2]};
    if (rows[r].mode == 2'h2) return {2'h0, d};
    return {4'h0, d[11:0]};
  endfunction
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(alss_pkg::ADDR_CTRL, st0);
    check(st0, alss_pkg::CTRL_RESET);
    rd(alss_pkg::ADDR_TIMING, st0);
    check(st0, alss_pkg::TIMING_RESET);
    rd(8'h10, st0);
    check(st0, 16'h0000);
    for (int r = 0; r < 6; r++) begin
      for (int l = 0; l < LANES; l++) sample_in[l*SW +: SW] <= rows[r].d ^ 14'(l);
      rx_bits <= (rows[r].mode == 2'h1) ? 4'ha : ((rows[r].mode == 2'h2) ? 4'he : 4'hc);
      rx_msb <= rows[r].msb;
      wr(alss_pkg::ADDR_CTRL, {13'h0000, rows[r].msb, rows[r].mode});
      repeat (3) next_word();
      for (int l = 0; l < LANES; l++) check(rx_word[l*SW +: SW], expect_word(r, l));
      // two words span nbits bit clock periods, whatever the starting phase
      takes = 0;
      bc_prev = bit_clock_out;
      repeat (2 * int'(rx_bits)) begin
        @(posedge clk);
        if (bit_clock_out === 1'b1 && bc_prev === 1'b0) takes++;
        bc_prev = bit_clock_out;
      end
      check(16'(takes), {12'h000, rx_bits});
    end
    for (int p = 0; p < 4; p++) begin
      wr(alss_pkg::ADDR_TIMING, {8'h00, 6'h39, 2'(p)});
      repeat (30) @(posedge clk);
      check({10'h000, bitclk_edge_delay, data_fall_delay, data_rise_delay}, 16'h0039);
    end
    wr(alss_pkg::ADDR_CTRL, 16'h0004);
    rd(alss_pkg::ADDR_STATUS, st0);
    pulse_sync();
    check({13'h0000, odd_sample_sel, rr, fr}, 16'h0001);
    rd(alss_pkg::ADDR_STATUS, st1);
    check({8'h00, st1[15:8]}, {8'h00, st0[15:8] + 8'h01});
    rx_bits <= 4'hc;
    rx_msb <= 1'b1;
    wr(alss_pkg::ADDR_CTRL, 16'h004c);
    pulse_sync();
    check({15'h0000, rr}, 16'h0001);
    repeat (2) next_word();
    st1 = 16'(rx_word[0 +: SW]);
    next_word();
    for (int l = 0; l < LANES; l++) check(16'(rx_word[l*SW +: SW]), st1 + 16'h0001);
    wr(alss_pkg::ADDR_CTRL, 16'h0024);
    pulse_sync();
    check({15'h0000, odd_sample_sel}, 16'h0000);
    repeat (12) @(posedge clk);
    check({15'h0000, odd_sample_sel}, 16'h0001);
    for (int dz = 0; dz < 2; dz++) begin
      wr(alss_pkg::ADDR_CTRL, dz ? 16'h0014 : 16'h0004);
      repeat (24) @(posedge clk);
      takes = 0;
      repeat (48) begin
        @(posedge clk);
        if (sample_take === 1'b1) takes++;
      end
      check(16'(takes), dz ? 16'h0002 : 16'h0004);
    end
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(alss_pkg::ADDR_CTRL, st0);
    check(st0, alss_pkg::CTRL_RESET);
    rd(alss_pkg::ADDR_TIMING, st0);
    check(st0, alss_pkg::TIMING_RESET);
    finish_test();
  end
endmodule
